// *** core/wdu_pkg.sv ***
// shared constants and types for the watchdog timer unit
package wdu_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_FLAGS_CLR = 8'h0c;
    // control register layout
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PS_LSB = 1;
    localparam int CTRL_PS_MSB = 5;
    localparam logic [7:0] CTRL_RESET = 8'h16;
    localparam logic [7:0] CTRL_MASK = 8'h3f;
    // status word bit positions
    localparam int ST_TO_BIT = 0;
    localparam int ST_PD_BIT = 1;
    localparam int ST_WATCHDOG_RESET_FLAG_N_BIT = 2;
    localparam int ST_ACTIVE_BIT = 3;
    localparam int ST_SLEEP_BIT = 4;
    // period coding
    localparam logic [4:0] PS_MAX_CODE = 5'h12;
    localparam int PS_BASE_SHIFT = 5;
    localparam int CNT_W = 24;
    // nominal oscillator rates
    localparam int LFOSC_HZ = 31000;
    localparam int BASE_INTERVAL_US = 1000;
    localparam int PCLK_HZ = 25000000;
    // operating modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SOFT = 2'h1;
    localparam logic [1:0] MODE_AWAKE = 2'h2;
    localparam logic [1:0] MODE_ON = 2'h3;
    // system clock source kinds
    typedef enum logic [2:0] {
        CLK_LOW_SPEED_CRYSTAL,
        CLK_HIGH_SPEED_CRYSTAL,
        CLK_LOW_POWER_CRYSTAL,
        CLK_OTHER
    } wdu_clksrc_t;
    // power and core events
    typedef struct packed {
        logic clear_watchdog_instruction;
        logic sleep_enter;
        logic sleep_wake;
        logic osc_fail;
        logic startup_delay_busy;
    } wdu_events_t;
    // status flags
    typedef struct packed {
        logic timeout_flag_n;
        logic powerdown_flag_n;
        logic watchdog_reset_flag_n;
    } wdu_flags_t;
endpackage

// *** core/wdu_sync.sv ***
// three-flop synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module wdu_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // first stage only feeds the second; output moves when 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_out <= s3_q;
            end
        end
    end
endmodule

// *** core/wdu_prescaler.sv ***
// oscillator-edge counter and period-code decode
`timescale 1ns/1ps
module wdu_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic tick,
    input wire logic [4:0] period_code,
    output logic expired
);
    logic [wdu_pkg::CNT_W-1:0] count_q;
    logic [wdu_pkg::CNT_W-1:0] limit;

    // codes above the top step fall back to the shortest 1:32 interval
    function automatic logic [wdu_pkg::CNT_W-1:0] limit_of(
        input logic [4:0] code
    );
        logic [4:0] c;
        c = (code > wdu_pkg::PS_MAX_CODE) ? 5'h00 : code;
        // 2^(n+5) oscillator cycles, last count value is that minus one
        limit_of = (wdu_pkg::CNT_W'(1) << (c + 5'(wdu_pkg::PS_BASE_SHIFT)))
            - wdu_pkg::CNT_W'(1);
    endfunction

    assign limit = limit_of(period_code);

    // counter is cleared whole so no partial interval survives a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            expired <= 1'b0;
        end else if (clk_en) begin
            expired <= 1'b0;
            if (clear) begin
                count_q <= '0;
            end else if (tick) begin
                if (count_q >= limit) begin
                    count_q <= '0;
                    expired <= 1'b1;
                end else begin
                    count_q <= count_q + wdu_pkg::CNT_W'(1);
                end
            end
        end
    end
endmodule

// *** core/wdu_top.sv ***
// watchdog timer unit with apb control and status registers
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module wdu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lf_osc,
    input wire logic [1:0] watchdog_mode_config,
    input wire wdu_pkg::wdu_clksrc_t clk_source,
    input wire wdu_pkg::wdu_events_t events,
    input wire logic [3:0] intosc_freq_select,
    input wire logic in_sleep,
    output logic system_reset,
    output logic sleep_wakeup,
    output wdu_pkg::wdu_flags_t flags
);
    logic osc_s;
    logic osc_prev_q;
    logic osc_tick;
    logic [7:0] ctrl_q;
    logic active;
    logic crystal_src;
    logic hold_startup_q;
    logic clear_all;
    logic expired;
    logic wr_en;
    logic flags_clr;
    logic to_q;
    logic pd_q;
    logic watchdog_reset_flag_n_q;
    logic unmapped;
    logic [31:0] rd_word;
    logic [4:0] period_code;
    logic soft_en;

    // oscillator arrives from its own domain, so it is resampled here
    wdu_sync u_osc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(lf_osc),
        .sync_out(osc_s)
    );

    // rising edge of the resampled oscillator marks one time-base tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev_q <= 1'b0;
        end else if (clk_en) begin
            osc_prev_q <= osc_s;
        end
    end
    assign osc_tick = osc_s & ~osc_prev_q;

    // divider select is accepted but deliberately not wired to the count
    logic unused_intosc_freq_select;
    assign unused_intosc_freq_select = ^intosc_freq_select;

    assign period_code = ctrl_q[wdu_pkg::CTRL_PS_MSB:wdu_pkg::CTRL_PS_LSB];
    assign soft_en = ctrl_q[wdu_pkg::CTRL_EN_BIT];

    // mode table decode
    always_comb begin
        unique case (watchdog_mode_config)
            wdu_pkg::MODE_ON: active = 1'b1;
            wdu_pkg::MODE_AWAKE: active = ~in_sleep;
            wdu_pkg::MODE_SOFT: active = soft_en;
            wdu_pkg::MODE_OFF: active = 1'b0;
        endcase
    end

    assign crystal_src = (clk_source == wdu_pkg::CLK_LOW_SPEED_CRYSTAL)
        || (clk_source == wdu_pkg::CLK_HIGH_SPEED_CRYSTAL)
        || (clk_source == wdu_pkg::CLK_LOW_POWER_CRYSTAL);

    // after a crystal wake the counter stays clear until startup is done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_startup_q <= 1'b0;
        end else if (clk_en) begin
            if (events.sleep_wake && crystal_src) begin
                hold_startup_q <= 1'b1;
            end else if (!events.startup_delay_busy) begin
                hold_startup_q <= 1'b0;
            end
        end
    end

    // every clearing condition folds into one strobe for the prescaler
    assign clear_all = ~active
        | events.clear_watchdog_instruction
        | events.sleep_enter
        | events.sleep_wake
        | events.osc_fail
        | events.startup_delay_busy
        | hold_startup_q;

    wdu_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .clear(clear_all),
        .tick(osc_tick),
        .period_code(period_code),
        .expired(expired)
    );

    // time-out splits into reset when awake and wake-up when asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset <= 1'b0;
            sleep_wakeup <= 1'b0;
        end else if (clk_en) begin
            system_reset <= expired & ~in_sleep;
            sleep_wakeup <= expired & in_sleep;
        end
    end

    // apb decode; zero-wait slave, access phase completes at once
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign unmapped = (paddr != wdu_pkg::ADDR_CONTROL)
        && (paddr != wdu_pkg::ADDR_STATUS)
        && (paddr != wdu_pkg::ADDR_CONFIG)
        && (paddr != wdu_pkg::ADDR_FLAGS_CLR);
    assign pslverr = psel & penable & unmapped;
    assign flags_clr = wr_en && (paddr == wdu_pkg::ADDR_FLAGS_CLR)
        && pwdata[wdu_pkg::ST_WATCHDOG_RESET_FLAG_N_BIT];

    // control register holds period select and soft enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= wdu_pkg::CTRL_RESET;
        end else if (clk_en) begin
            if (wr_en && paddr == wdu_pkg::ADDR_CONTROL) begin
                ctrl_q <= pwdata[7:0] & wdu_pkg::CTRL_MASK;
            end
        end
    end

    // status flags, active low, all set high by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (clk_en) begin
            if (expired) begin
                to_q <= 1'b0;
                pd_q <= ~in_sleep;
            end else if (events.sleep_enter) begin
                to_q <= 1'b1;
                pd_q <= 1'b0;
            end else if (events.clear_watchdog_instruction) begin
                to_q <= 1'b1;
                pd_q <= 1'b1;
            end
        end
    end

    // reset cause flag; an awake time-out in the same cycle beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset_flag_n_q <= 1'b1;
        end else if (clk_en) begin
            if (expired && !in_sleep) begin
                watchdog_reset_flag_n_q <= 1'b0;
            end else if (flags_clr) begin
                watchdog_reset_flag_n_q <= 1'b1;
            end
        end
    end

    // one driver for the whole flag word keeps the struct single-sourced
    assign flags = '{timeout_flag_n: to_q, powerdown_flag_n: pd_q,
        watchdog_reset_flag_n: watchdog_reset_flag_n_q};

    // read mux
    always_comb begin
        rd_word = '0;
        unique case (paddr)
            wdu_pkg::ADDR_CONTROL: rd_word[7:0] = ctrl_q;
            wdu_pkg::ADDR_STATUS: begin
                rd_word[wdu_pkg::ST_TO_BIT] = flags.timeout_flag_n;
                rd_word[wdu_pkg::ST_PD_BIT] = flags.powerdown_flag_n;
                rd_word[wdu_pkg::ST_WATCHDOG_RESET_FLAG_N_BIT] = flags.watchdog_reset_flag_n;
                rd_word[wdu_pkg::ST_ACTIVE_BIT] = active;
                rd_word[wdu_pkg::ST_SLEEP_BIT] = in_sleep;
            end
            wdu_pkg::ADDR_CONFIG: rd_word[1:0] = watchdog_mode_config;
            default: rd_word = '0;
        endcase
    end

    // read data registered at the edge that ends the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= rd_word;
        end
    end
endmodule

// *** dv/wdu_chk.sv ***
// port checker for the watchdog timer unit
`timescale 1ns/1ps
module wdu_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic [1:0] watchdog_mode_config,
    input wire wdu_pkg::wdu_events_t events,
    input wire logic in_sleep,
    input wire logic system_reset,
    input wire logic sleep_wakeup,
    input wire wdu_pkg::wdu_flags_t flags
);
    logic [2:0] off_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles with the mode off; saturates so an expiry in flight may land
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_q <= 3'h0;
        end else if (watchdog_mode_config != wdu_pkg::MODE_OFF) begin
            off_q <= 3'h0;
        end else if (off_q != 3'h7) begin
            off_q <= off_q + 3'h1;
        end
    end
    // bus, pulse and flag relations
    unmapped_err_a: assert property (
        psel && penable && paddr > 8'h0c |-> pslverr) else $error("no err");
    pulse_once_a: assert property (
        system_reset |=> !system_reset) else $error("long reset pulse");
    reset_awake_a: assert property (
        system_reset |-> !$past(in_sleep)) else $error("reset in sleep");
    wake_asleep_a: assert property (
        sleep_wakeup |-> $past(in_sleep)) else $error("wake while awake");
    timeout_flags_a: assert property (
        system_reset |-> ##[0:1] (!flags.timeout_flag_n
        && !flags.watchdog_reset_flag_n)) else $error("flags not set");
    sleep_flags_a: assert property (
        events.sleep_enter |-> ##[1:2] (flags.timeout_flag_n
        && !flags.powerdown_flag_n)) else $error("sleep flags wrong");
    clear_quiet_a: assert property (
        events.clear_watchdog_instruction |-> ##2 !system_reset [*6])
        else $error("reset soon after clear");
    off_quiet_a: assert property (
        off_q == 3'h7 |-> !system_reset && !sleep_wakeup)
        else $error("pulse while off");
    cover property (system_reset);
    cover property (sleep_wakeup);
    cover property (psel && penable && pslverr);
endmodule

bind wdu_top wdu_chk wdu_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
    .watchdog_mode_config(watchdog_mode_config), .events(events),
    .in_sleep(in_sleep), .system_reset(system_reset),
    .sleep_wakeup(sleep_wakeup), .flags(flags));

// *** dv/wdu_core_model.sv ***
// oscillator and clearing core in front of the watchdog
`timescale 1ns/1ps
module wdu_core_model #(
    parameter int HALF_NS = 210,
    parameter int KICK = 200
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic kick_en,
    output logic lf_osc,
    output logic clr_pulse
);
    int kick_n;
    // free-running, sped up to keep runs short; never stops in sleep
    initial begin
        lf_osc = 1'b0;
        forever #(HALF_NS) lf_osc = ~lf_osc;
    end
    // clear well inside the shortest time-out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kick_n <= 0;
            clr_pulse <= 1'b0;
        end else begin
            clr_pulse <= kick_en && kick_n == KICK - 1;
            kick_n <= (kick_n == KICK - 1) ? 0 : kick_n + 1;
        end
    end
endmodule

// *** dv/wdu_top_tb.sv ***
// self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
module wdu_top_tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lf_osc;
    logic [1:0] mode;
    logic [4:0] ev;
    logic clr_pulse;
    logic kick_en;
    logic [3:0] intosc;
    logic in_sleep;
    logic clk_en;
    wdu_pkg::wdu_clksrc_t clk_src;
    logic system_reset;
    logic sleep_wakeup;
    wdu_pkg::wdu_events_t events;
    wdu_pkg::wdu_flags_t flags;
    int n_fail;
    int tests_run;
    int n;
    logic [31:0] q;
    logic e;
    // core clears merge with the bench's own event pulses
    assign events = ev | {clr_pulse, 4'h0};
    wdu_top wdu_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lf_osc(lf_osc), .watchdog_mode_config(mode),
        .clk_source(clk_src), .events(events),
        .intosc_freq_select(intosc), .in_sleep(in_sleep),
        .system_reset(system_reset), .sleep_wakeup(sleep_wakeup),
        .flags(flags));
    wdu_core_model wdu_core_model_i (.pclk(pclk), .presetn(presetn),
        .kick_en(kick_en), .lf_osc(lf_osc), .clr_pulse(clr_pulse));
    // clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; result left in q and e
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never reassigns psel at once
        @(posedge pclk);
    endtask
    // cycles until a pulse, lim if none came
    task automatic wait_pulse(input logic slp, input int lim);
        n = 0;
        while (n < lim && (slp ? sleep_wakeup : system_reset) !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic t_reset();
        apb(1'b0, wdu_pkg::ADDR_CONTROL, 32'h0);
        chk(q, 32'h16);
        apb(1'b0, wdu_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h07);
        apb(1'b1, wdu_pkg::ADDR_CONTROL, 32'hff);
        apb(1'b0, wdu_pkg::ADDR_CONTROL, 32'h0);
        chk(q, 32'h3f);
        // a write while the clock enable is low must not land
        clk_en <= 1'b0;
        apb(1'b1, wdu_pkg::ADDR_CONTROL, 32'h0);
        clk_en <= 1'b1;
        apb(1'b0, wdu_pkg::ADDR_CONTROL, 32'h0);
        chk(q, 32'h3f);
        apb(1'b0, 8'h10, 32'h0);
        chk({q[30:0], e}, 32'h1);
    endtask
    // a setting that must never time out
    task automatic t_quiet(input logic [1:0] m, input logic [31:0] c,
        input logic s, input logic k);
        apb(1'b1, wdu_pkg::ADDR_CONTROL, c);
        mode <= m;
        in_sleep <= s;
        kick_en <= k;
        wait_pulse(s, 800);
        chk(n, 800);
        mode <= wdu_pkg::MODE_OFF;
        in_sleep <= 1'b0;
        kick_en <= 1'b0;
    endtask
    // run to a time-out while awake, then clear the flags again
    task automatic t_timeout(input logic [1:0] m, input logic [31:0] c,
        input int ticks);
        apb(1'b1, wdu_pkg::ADDR_CONTROL, c);
        mode <= m;
        intosc <= ~intosc;
        wait_pulse(1'b0, ticks * 11);
        chk(32'(n > ticks * 21 / 2 - 16 && n < ticks * 21 / 2 + 16), 1);
        repeat (2) @(posedge pclk);
        chk({29'h0, flags}, 32'h2);
        apb(1'b0, wdu_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h0a);
        apb(1'b1, wdu_pkg::ADDR_FLAGS_CLR, 32'h4);
        ev[4] <= 1'b1;
        @(posedge pclk);
        ev[4] <= 1'b0;
        mode <= wdu_pkg::MODE_OFF;
        repeat (2) @(posedge pclk);
        chk({29'h0, flags}, 32'h7);
    endtask
    // time-out in sleep wakes instead of resetting
    task automatic t_sleep();
        apb(1'b1, wdu_pkg::ADDR_CONTROL, 32'h0);
        mode <= wdu_pkg::MODE_ON;
        ev[3] <= 1'b1;
        in_sleep <= 1'b1;
        @(posedge pclk);
        ev[3] <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({29'h0, flags}, 32'h5);
        wait_pulse(1'b1, 400);
        chk(32'(n > 300 && n < 360), 32'h1);
        repeat (2) @(posedge pclk);
        chk({29'h0, flags}, 32'h1);
        ev[2] <= 1'b1;
        in_sleep <= 1'b0;
        mode <= wdu_pkg::MODE_OFF;
        @(posedge pclk);
        ev[2] <= 1'b0;
    endtask
    // crystal wake holds the count clear, osc fail restarts it, then reset
    task automatic t_startup();
        apb(1'b1, wdu_pkg::ADDR_CONTROL, 32'h0);
        clk_src <= wdu_pkg::CLK_HIGH_SPEED_CRYSTAL;
        mode <= wdu_pkg::MODE_ON;
        ev <= 5'h05;
        @(posedge pclk);
        ev <= 5'h01;
        wait_pulse(1'b0, 400);
        chk(n, 400);
        ev <= 5'h00;
        repeat (200) @(posedge pclk);
        ev <= 5'h02;
        @(posedge pclk);
        ev <= 5'h00;
        wait_pulse(1'b0, 352);
        chk(32'(n > 320 && n < 352), 1);
        mode <= wdu_pkg::MODE_OFF;
        clk_src <= wdu_pkg::CLK_OTHER;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({29'h0, flags}, 32'h7);
        apb(1'b0, wdu_pkg::ADDR_CONTROL, 32'h0);
        chk(q, 32'h16);
    endtask
    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard, well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mode = wdu_pkg::MODE_OFF;
        ev = 5'h00;
        kick_en = 1'b0;
        intosc = 4'h0;
        in_sleep = 1'b0;
        clk_en = 1'b1;
        clk_src = wdu_pkg::CLK_OTHER;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_quiet(wdu_pkg::MODE_OFF, 32'h01, 1'b0, 1'b0);
        t_quiet(wdu_pkg::MODE_SOFT, 32'h00, 1'b0, 1'b0);
        t_quiet(wdu_pkg::MODE_AWAKE, 32'h00, 1'b1, 1'b0);
        t_quiet(wdu_pkg::MODE_ON, 32'h00, 1'b0, 1'b1);
        t_timeout(wdu_pkg::MODE_ON, 32'h00, 32);
        t_timeout(wdu_pkg::MODE_SOFT, 32'h05, 128);
        t_timeout(wdu_pkg::MODE_AWAKE, 32'h3e, 32);
        t_sleep();
        t_startup();
        final_report();
    end
endmodule
